// ==== verilog/sit_pkg.sv ====
// sit_pkg: constants, types and decode helpers for the 16-bit interval timer.
// Assumes one clock domain (mclk, 10 MHz) and a 16-bit register port.
`default_nettype none

package sit_pkg;

	// register port shape
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;

	// register offsets (word index on the register port)
	localparam logic [2:0] OFS_CONTROL = 3'h0;
	localparam logic [2:0] OFS_COUNT = 3'h1;
	localparam logic [2:0] OFS_PERIOD = 3'h2;
	localparam logic [2:0] OFS_STATUS = 3'h3;
	localparam logic [2:0] OFS_MASK = 3'h4;

	// timer_control field positions
	localparam int BIT_RUN = 15;
	localparam int BIT_IDLE_STOP = 13;
	localparam int BIT_GATE_ACC = 6;
	localparam int BIT_PS_HI = 5;
	localparam int BIT_PS_LO = 4;
	localparam int BIT_SYNC = 2;
	localparam int BIT_SRC = 1;

	// implemented control bits; all others read as zero
	localparam logic [15:0] CTL_WRITABLE = 16'ha076;

	// status and mask layout
	localparam int ST_W = 2;
	localparam int ST_PERIOD = 0;
	localparam int ST_GATE = 1;

	// reset values
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hffff;
	localparam logic [15:0] DATA_ZERO = 16'h0000;
	localparam logic [1:0] ST_ZERO = 2'h0;

	// prescaler: last value of the divide counter per setting
	localparam int PS_W = 8;
	localparam logic [7:0] PS_LAST_1 = 8'h00;
	localparam logic [7:0] PS_LAST_8 = 8'h07;
	localparam logic [7:0] PS_LAST_64 = 8'h3f;
	localparam logic [7:0] PS_LAST_256 = 8'hff;
	localparam logic [1:0] PS_SEL_1 = 2'h0;
	localparam logic [1:0] PS_SEL_8 = 2'h1;
	localparam logic [1:0] PS_SEL_64 = 2'h2;

	typedef enum logic [1:0] {
		MODE_TIMER,
		MODE_GATED,
		MODE_SYNC_CNT,
		MODE_ASYNC_CNT
	} sit_mode_type;

	// one register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} sit_bus_req_type;

	// operating mode from the control word
	function automatic sit_mode_type sit_mode(input logic [15:0] ctl);
		if (ctl[BIT_SRC]) begin
			sit_mode = ctl[BIT_SYNC] ? MODE_SYNC_CNT : MODE_ASYNC_CNT;
		end else begin
			sit_mode = ctl[BIT_GATE_ACC] ? MODE_GATED : MODE_TIMER;
		end
	endfunction : sit_mode

	// terminal count of the prescaler for a select code
	function automatic logic [7:0] sit_ps_last(input logic [1:0] sel);
		if (sel == PS_SEL_1) begin
			sit_ps_last = PS_LAST_1;
		end else if (sel == PS_SEL_8) begin
			sit_ps_last = PS_LAST_8;
		end else if (sel == PS_SEL_64) begin
			sit_ps_last = PS_LAST_64;
		end else begin
			sit_ps_last = PS_LAST_256;
		end
	endfunction : sit_ps_last

endpackage : sit_pkg

`default_nettype wire

// ==== verilog/sit_prescaler.sv ====
// sit_prescaler: divides a stream of input ticks by 1, 8, 64 or 256.
// Assumes tick_in is sampled every mclk, each high cycle one tick; tick_out is combinational.
`timescale 1ns/1ps
`default_nettype none

module sit_prescaler
	import sit_pkg::*;
(
	input wire logic mclk, // system clock
	input wire logic reset, // synchronous, active high
	input wire logic clear, // restart the divide count
	input wire logic tick_in, // input tick pulse
	input wire logic [1:0] ratio, // prescale select code
	output logic tick_out // divided tick pulse
);

	typedef struct packed {
		logic [PS_W-1:0] cnt;
	} sit_ps_state_type;

	sit_ps_state_type st;
	sit_ps_state_type next_st;
	logic [PS_W-1:0] last;

	// terminal count from the select code; 1:1 passes every tick
	always_comb begin
		last = sit_ps_last(ratio);
		tick_out = tick_in && (st.cnt == last);
		next_st = st;
		if (clear) begin
			next_st.cnt = '0;
		end else if (tick_in) begin
			next_st.cnt = (st.cnt == last) ? '0 : PS_W'(st.cnt + 1'b1);
		end
	end

	// state register
	always_ff @(posedge mclk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// every control write clears the count, so a new ratio never starts past its end
	a_ps_in_range: assert property (@(posedge mclk) disable iff (reset)
		st.cnt <= last)
		else $error("prescaler count past its terminal value");

endmodule : sit_prescaler

`default_nettype wire

// ==== verilog/sit_timer.sv ====
// sit_timer: 16-bit interval timer / event counter with prescaler and period match.
// Assumes pins and register port are synchronous to mclk; read data one cycle later.
//
// Operation
// - A 16-bit up counter runs freely as timer or event counter while enabled.
// - An asynchronous counter mode counts the external pin with no synchroniser stage.
// - In synchronous counter mode the prescaler output, not the raw pin, is synchronised.
// - Timer and gated timer modes count the internal instruction clock.
// - Both counter modes count the external count pin.
// - Mode comes from source select with gate enable, or source select with sync select.
// - With idle-stop bit 13 set the module halts while the device is idle.
// - Gate accumulate bit 6 acts only with the internal source and is ignored otherwise.
// - Prescale field bits 5-4 divide by 256, 64, 8 or 1 for codes 11, 10, 01, 00.
// - Bit 2 synchronises the prescaled external input when the external source is chosen.
// - Bit 1 selects the external pin on its rising edge, or the internal clock when 0.
// - Software writes to the count are ignored while running as synchronous counter.
// - Unimplemented control bits 14, 12-7, 3 and 0 read as zero.
`timescale 1ns/1ps
`default_nettype none

module sit_timer
	import sit_pkg::*;
(
	input wire logic mclk, // system clock, 10 MHz
	input wire logic reset, // synchronous, active high
	input wire sit_bus_req_type bus_req, // register port request
	output logic [DATA_W-1:0] bus_rdata, // read data, cycle after read
	input wire logic idle_mode, // device is in idle
	input wire logic external_count_pin, // count clock or gate input
	output logic irq // level interrupt
);

	typedef struct packed {
		logic [15:0] control;
		logic [15:0] count;
		logic [15:0] period;
		logic [ST_W-1:0] status;
		logic [ST_W-1:0] mask;
		logic pin_prev;
		logic sync1;
		logic sync2;
		logic [DATA_W-1:0] rdata;
	} sit_state_type;

	sit_state_type st;
	sit_state_type next_st;
	sit_mode_type mode;
	logic running;
	logic pin_rise;
	logic gate_fall;
	logic ps_in;
	logic ps_tick;
	logic ps_clear;
	logic count_tick;
	logic count_wr;
	logic count_wr_ok;
	logic period_hit;

	// mode and run decode
	always_comb begin
		mode = sit_mode(st.control);
		running = st.control[BIT_RUN] && !(st.control[BIT_IDLE_STOP] && idle_mode);
		pin_rise = external_count_pin && !st.pin_prev;
		gate_fall = (mode == MODE_GATED) && running && st.pin_prev
			&& !external_count_pin;
	end

	// prescaler input selection per mode
	always_comb begin
		case (mode)
			MODE_TIMER: ps_in = running;
			MODE_GATED: ps_in = running && external_count_pin;
			default: ps_in = running && pin_rise;
		endcase
	end

	// software write to the count; blocked in running synchronous counter mode
	always_comb begin
		count_wr = bus_req.wr && (bus_req.addr == OFS_COUNT);
		count_wr_ok = count_wr && !(st.control[BIT_RUN] && mode == MODE_SYNC_CNT);
		ps_clear = count_wr_ok || (bus_req.wr && bus_req.addr == OFS_CONTROL);
	end

	sit_prescaler sit_prescaler_i (
		.mclk(mclk),
		.reset(reset),
		.clear(ps_clear),
		.tick_in(ps_in),
		.ratio(st.control[BIT_PS_HI:BIT_PS_LO]),
		.tick_out(ps_tick)
	);

	// the async path uses the prescaled pin directly; sync path waits two flops
	always_comb begin
		if (mode == MODE_SYNC_CNT) begin
			count_tick = st.sync2 && running;
		end else begin
			count_tick = ps_tick;
		end
		period_hit = count_tick && (st.count == st.period);
	end

	// next state: counter, registers, flags, read data
	always_comb begin
		next_st = st;
		next_st.rdata = DATA_ZERO;
		next_st.pin_prev = external_count_pin;
		// first flop feeds only the second
		next_st.sync1 = ps_tick && (mode == MODE_SYNC_CNT);
		next_st.sync2 = st.sync1;

		// counting; a match wraps to zero on the count clock after it
		if (count_tick) begin
			if (period_hit) begin
				next_st.count = COUNT_RESET;
			end else begin
				next_st.count = 16'(st.count + 1'b1);
			end
		end

		// software writes win over a count tick in the same cycle
		if (bus_req.wr) begin
			if (bus_req.addr == OFS_CONTROL) begin
				next_st.control = bus_req.wdata & CTL_WRITABLE;
			end else if (bus_req.addr == OFS_COUNT) begin
				if (count_wr_ok) begin
					next_st.count = bus_req.wdata;
				end
			end else if (bus_req.addr == OFS_PERIOD) begin
				next_st.period = bus_req.wdata;
			end else if (bus_req.addr == OFS_MASK) begin
				next_st.mask = bus_req.wdata[ST_W-1:0];
			end
		end

		// reads; status clears on read
		if (bus_req.rd) begin
			if (bus_req.addr == OFS_CONTROL) begin
				next_st.rdata = st.control & CTL_WRITABLE;
			end else if (bus_req.addr == OFS_COUNT) begin
				next_st.rdata = st.count;
			end else if (bus_req.addr == OFS_PERIOD) begin
				next_st.rdata = st.period;
			end else if (bus_req.addr == OFS_STATUS) begin
				next_st.rdata = {{(DATA_W-ST_W){1'b0}}, st.status};
				next_st.status = ST_ZERO;
			end else if (bus_req.addr == OFS_MASK) begin
				next_st.rdata = {{(DATA_W-ST_W){1'b0}}, st.mask};
			end
		end

		// events set after the clear so a same-cycle event is kept
		if (period_hit && mode != MODE_GATED) begin
			next_st.status[ST_PERIOD] = 1'b1;
		end
		if (gate_fall) begin
			next_st.status[ST_GATE] = 1'b1;
		end
	end

	// state register
	always_ff @(posedge mclk) begin
		if (reset) begin
			st.control <= CTL_RESET;
			st.count <= COUNT_RESET;
			st.period <= PERIOD_RESET;
			st.status <= ST_ZERO;
			st.mask <= ST_ZERO;
			st.pin_prev <= 1'b0;
			st.sync1 <= 1'b0;
			st.sync2 <= 1'b0;
			st.rdata <= DATA_ZERO;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign bus_rdata = st.rdata;
	assign irq = |(st.status & st.mask);

	// unimplemented control bits never read back as one
	a_ctl_read_zero: assert property (@(posedge mclk) disable iff (reset)
		bus_req.rd && bus_req.addr == OFS_CONTROL |=> (bus_rdata & ~CTL_WRITABLE) == DATA_ZERO)
		else $error("unimplemented control bit read as one");

	// count write ignored in running synchronous counter mode
	a_sync_write_block: assert property (@(posedge mclk) disable iff (reset)
		count_wr && st.control[BIT_RUN] && mode == MODE_SYNC_CNT && !count_tick
		|=> st.count == $past(st.count))
		else $error("count written in synchronous counter mode");

	// a stopped timer holds its count
	a_stop_holds: assert property (@(posedge mclk) disable iff (reset)
		!st.control[BIT_RUN] && !st.sync2 && !count_wr |=> $stable(st.count))
		else $error("count moved while stopped");

	// idle with idle-stop set halts counting
	a_idle_halts: assert property (@(posedge mclk) disable iff (reset)
		st.control[BIT_IDLE_STOP] && idle_mode && !count_wr |=> $stable(st.count))
		else $error("count moved in idle with idle stop");

	// timer mode at 1:1 counts every internal clock
	a_timer_counts: assert property (@(posedge mclk) disable iff (reset)
		mode == MODE_TIMER && running && st.control[BIT_PS_HI:BIT_PS_LO] == PS_SEL_1
		&& st.count != st.period && !count_wr
		|=> st.count == 16'($past(st.count) + 1'b1))
		else $error("timer mode did not count");

	// outside gated mode a period match wraps to zero and raises the flag
	a_period_wrap: assert property (@(posedge mclk) disable iff (reset)
		period_hit && mode != MODE_GATED && !count_wr
		|=> st.count == COUNT_RESET && st.status[ST_PERIOD])
		else $error("period match did not wrap or flag");

	// gated mode holds the count while the gate is low
	a_gate_low_hold: assert property (@(posedge mclk) disable iff (reset)
		mode == MODE_GATED && !external_count_pin && !count_wr |=> $stable(st.count))
		else $error("gated count moved with gate low");

	// gate falling edge sets the gate flag
	a_gate_fall_flag: assert property (@(posedge mclk) disable iff (reset)
		gate_fall |=> st.status[ST_GATE])
		else $error("gate falling edge not flagged");

	// async counter at 1:1 counts a pin rise in the next cycle
	a_async_edge: assert property (@(posedge mclk) disable iff (reset)
		mode == MODE_ASYNC_CNT && running && pin_rise && !ps_clear
		&& st.control[BIT_PS_HI:BIT_PS_LO] == PS_SEL_1 && st.count != st.period
		|=> st.count == 16'($past(st.count) + 1'b1))
		else $error("async counter missed a pin rise");

	// sync counter sees the prescaled tick two cycles later
	a_sync_latency: assert property (@(posedge mclk) disable iff (reset)
		mode == MODE_SYNC_CNT && ps_tick ##1 mode == MODE_SYNC_CNT |=> st.sync2)
		else $error("synchronised tick not two cycles late");

	// external source never raises the gate flag, whatever the gate bit says
	a_gate_ignored: assert property (@(posedge mclk) disable iff (reset)
		st.control[BIT_SRC] && !st.status[ST_GATE] |=> !st.status[ST_GATE])
		else $error("gate bit acted with external source");

	// count reads return the count of the strobe cycle
	a_count_read: assert property (@(posedge mclk) disable iff (reset)
		bus_req.rd && bus_req.addr == OFS_COUNT |=> bus_rdata == $past(st.count))
		else $error("count read returned a stale value");

	// an unmapped index reads as zero
	a_unmapped_zero: assert property (@(posedge mclk) disable iff (reset)
		bus_req.rd && bus_req.addr > OFS_MASK |=> bus_rdata == DATA_ZERO)
		else $error("unmapped index read as nonzero");

	// period register takes a write as given
	a_period_write: assert property (@(posedge mclk) disable iff (reset)
		bus_req.wr && bus_req.addr == OFS_PERIOD |=> st.period == $past(bus_req.wdata))
		else $error("period write not taken");

	// control keeps only the implemented bits of a write
	a_control_write: assert property (@(posedge mclk) disable iff (reset)
		bus_req.wr && bus_req.addr == OFS_CONTROL
		|=> st.control == ($past(bus_req.wdata) & CTL_WRITABLE))
		else $error("control write not masked to implemented bits");

	// an accepted count write wins over a tick in the same cycle
	a_count_write_wins: assert property (@(posedge mclk) disable iff (reset)
		count_wr_ok |=> st.count == $past(bus_req.wdata))
		else $error("accepted count write lost");

	// async counter moves only on a pin rise
	a_async_rise_only: assert property (@(posedge mclk) disable iff (reset)
		mode == MODE_ASYNC_CNT && !pin_rise && !count_wr |=> $stable(st.count))
		else $error("async counter moved without a pin rise");

	// sync counter moves only when the second flop carries a tick
	a_sync_second_flop: assert property (@(posedge mclk) disable iff (reset)
		mode == MODE_SYNC_CNT && !st.sync2 && !count_wr |=> $stable(st.count))
		else $error("sync counter moved without a synchronised tick");

	// gated mode at 1:1 counts every cycle the gate is high
	a_gate_high_counts: assert property (@(posedge mclk) disable iff (reset)
		mode == MODE_GATED && running && external_count_pin
		&& st.control[BIT_PS_HI:BIT_PS_LO] == PS_SEL_1 && st.count != st.period && !count_wr
		|=> st.count == 16'($past(st.count) + 1'b1))
		else $error("gated count missed a gate-high cycle");

	// the period flag is sticky until a status read
	a_period_sticky: assert property (@(posedge mclk) disable iff (reset)
		st.status[ST_PERIOD] && !(bus_req.rd && bus_req.addr == OFS_STATUS)
		|=> st.status[ST_PERIOD])
		else $error("period flag dropped without a status read");

	// the period flag rises only on a period match
	a_period_flag_cause: assert property (@(posedge mclk) disable iff (reset)
		!period_hit && !st.status[ST_PERIOD] |=> !st.status[ST_PERIOD])
		else $error("period flag set without a match");

	// a status read with no new event leaves status empty
	a_status_read_clear: assert property (@(posedge mclk) disable iff (reset)
		bus_req.rd && bus_req.addr == OFS_STATUS && !period_hit && !gate_fall
		|=> st.status == ST_ZERO)
		else $error("status not cleared by its read");

endmodule : sit_timer

`default_nettype wire

// ==== tb/sit_pin_source.sv ====
// sit_pin_source: stands in for the external clock or gate source on the count pin.
// Assumes one mclk domain; the pin idles low between bursts and gate windows.
`timescale 1ns/1ps
`default_nettype none

module sit_pin_source (
	input wire logic mclk, // system clock
	output logic pin // drives external_count_pin
);
	initial begin
		pin = 1'b0;
	end

	// rising edges one high cycle apart by two low cycles, slow enough for sync mode
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge mclk);
			pin <= 1'b1;
			@(posedge mclk);
			pin <= 1'b0;
			@(posedge mclk);
		end
	endtask : pulse

	// gate held high for exactly n sampled cycles, then a falling edge
	task automatic gate(input int n);
		@(posedge mclk);
		pin <= 1'b1;
		repeat (n) @(posedge mclk);
		pin <= 1'b0;
	endtask : gate
endmodule : sit_pin_source

`default_nettype wire

// ==== tb/sit_timer_tb.sv ====
// sit_timer_tb: register port tests of the interval timer.
// Assumes sit_pin_source on the count pin and one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module sit_timer_tb
	import sit_pkg::*;
;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	sit_bus_req_type bus_req = '0;
	logic [DATA_W-1:0] bus_rdata;
	logic idle_mode = 1'b0;
	logic pin;
	logic irq;
	logic [15:0] rv;
	int miscompares = 0;
	int total_checks = 0;
	int dv[4] = '{1, 8, 64, 256};
	logic [15:0] rst_v[6] = '{16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h0000};

	// 100 ns period
	initial begin
		forever #50 mclk = ~mclk;
	end

	sit_timer sit_timer_i (.mclk(mclk), .reset(reset), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .idle_mode(idle_mode), .external_count_pin(pin), .irq(irq));
	sit_pin_source sit_pin_source_i (.mclk(mclk), .pin(pin));

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one-cycle write strobe
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus_req.wr <= 1'b0;
		#1;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus_req.rd <= 1'b0;
		#1;
		rv = bus_rdata;
	endtask : rd

	// margin of a quarter divide keeps the result clear of tick boundaries
	task automatic run_cnt(input logic [15:0] ctl, input int n);
		wr(OFS_COUNT, 16'h0000);
		wr(OFS_CONTROL, ctl);
		repeat (n) @(posedge mclk);
		wr(OFS_CONTROL, 16'h0000);
		rd(OFS_COUNT);
	endtask : run_cnt

	// pin-driven modes, then a count write while running
	task automatic pulse_test(input logic [15:0] ctl, input int n, input logic [15:0] exp);
		wr(OFS_COUNT, 16'h0000);
		wr(OFS_CONTROL, ctl);
		sit_pin_source_i.pulse(n);
		repeat (4) @(posedge mclk);
		rd(OFS_COUNT);
		chk("pin count", rv, exp);
		wr(OFS_COUNT, 16'h0100);
		rd(OFS_COUNT);
		chk("count write", rv, ctl[BIT_SYNC] ? exp : 16'h0100);
		wr(OFS_CONTROL, 16'h0000);
	endtask : pulse_test

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict

	// hang guard, far beyond the roughly 1400 cycles the tests need
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		give_verdict();
	end

	initial begin
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		// reset values, unmapped index 5 included
		for (int i = 0; i < 6; i++) begin
			rd(i[2:0]);
			chk("reset value", rv, rst_v[i]);
		end
		chk("irq after reset", {15'h0000, irq}, 16'h0000);
		wr(OFS_CONTROL, 16'hffff);
		rd(OFS_CONTROL);
		chk("control bits", rv, 16'ha076);
		wr(OFS_CONTROL, 16'h0000);
		// period match at 1:1, masked first, then unmasked
		wr(OFS_PERIOD, 16'h0002);
		wr(OFS_CONTROL, 16'h8000);
		repeat (10) @(posedge mclk);
		wr(OFS_CONTROL, 16'h0000);
		chk("irq masked", {15'h0000, irq}, 16'h0000);
		wr(OFS_MASK, 16'h0001);
		chk("irq period", {15'h0000, irq}, 16'h0001);
		rd(OFS_STATUS);
		chk("status period", rv, 16'h0001);
		chk("irq cleared", {15'h0000, irq}, 16'h0000);
		rd(OFS_STATUS);
		chk("status empty", rv, 16'h0000);
		wr(OFS_PERIOD, 16'hffff);
		// prescale codes 01, 10 and 11; sync bit set on every run must be ignored
		for (int c = 1; c < 4; c++) begin
			run_cnt(16'h8000 | (16'(c) << BIT_PS_LO) | 16'h0004, dv[c] * 3 + dv[c] / 4);
			chk("prescaled count", rv, 16'h0003);
		end
		// idle stop against idle run
		idle_mode <= 1'b1;
		run_cnt(16'ha010, 26);
		chk("idle stopped", rv, 16'h0000);
		run_cnt(16'h8010, 26);
		chk("idle running", rv, 16'h0003);
		idle_mode <= 1'b0;
		pulse_test(16'h8042, 5, 16'h0005);
		pulse_test(16'h8006, 5, 16'h0005);
		pulse_test(16'h8012, 16, 16'h0002);
		// gated accumulation and its falling-edge flag
		wr(OFS_COUNT, 16'h0000);
		wr(OFS_MASK, 16'h0002);
		wr(OFS_CONTROL, 16'h8040);
		sit_pin_source_i.gate(20);
		repeat (3) @(posedge mclk);
		chk("irq gate", {15'h0000, irq}, 16'h0001);
		wr(OFS_CONTROL, 16'h0000);
		rd(OFS_COUNT);
		chk("gated count", rv, 16'd20);
		rd(OFS_STATUS);
		chk("status gate", rv, 16'h0002);
		chk("irq gate cleared", {15'h0000, irq}, 16'h0000);
		give_verdict();
	end
endmodule : sit_timer_tb

`default_nettype wire
